// file: logic/pss_cfg.svh
// constants of the pipelined synchronous sram port: widths, depths, counts
// assumes nothing; included by the package, the sram port and the testbench files
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

`define PSS_ADDR_W 19
`define PSS_DATA_W 32
`define PSS_LANES 4
`define PSS_LANE_W 8
`define PSS_BURST_W 2
`define PSS_FIFO_DEPTH 8
`define PSS_SLEEP_CYCLES 2
`define PSS_CLK_PERIOD_NS 10

`endif

// file: logic/pss_pkg.sv
// types shared by the sram port and its testbench
// assumes pss_cfg.svh is reachable on the include path
`include "pss_cfg.svh"

package pss_pkg;

    // enum order matches the strap level: low is linear, high is interleaved
    typedef enum logic {
        PSS_LINEAR,
        PSS_INTERLEAVED
    } pss_order_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [`PSS_ADDR_W-1:0] addr;
    } pss_cmd_t;

    typedef struct packed {
        logic [`PSS_LANES-1:0] parity;
        logic [`PSS_DATA_W-1:0] data;
    } pss_word_t;

    typedef struct packed {
        logic [`PSS_ADDR_W-1:0] addr;
        logic [`PSS_LANES-1:0] laneSel_n;
        pss_word_t word;
    } pss_wr_t;

endpackage

// file: logic/pss_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock, DEPTH a power of two
`timescale 1ns/1ps

module pss_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int PtrW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [0:DEPTH-1];
    logic [PtrW-1:0] wrPtr_ff;
    logic [PtrW-1:0] rdPtr_ff;
    logic [PtrW:0] count_ff;
    logic push;
    logic pop;

    assign inReady = count_ff != (PtrW+1)'(DEPTH);
    assign outValid = count_ff != '0;
    assign outData = store[rdPtr_ff];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // storage is not reset: only slots between the pointers are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            store[wrPtr_ff] <= inData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
        end else begin
            if (push) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (pop) begin
                rdPtr_ff <= rdPtr_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_ff <= '0;
        end else begin
            case ({push, pop})
                2'b10: count_ff <= count_ff + 1'b1;
                2'b01: count_ff <= count_ff - 1'b1;
                default: count_ff <= count_ff;
            endcase
        end
    end

endmodule

// file: logic/pss_sram_port.sv
// pipelined burst sram with a shared data/parity bus, seen from its pins
// assumes every input is synchronous to sys_clk; the testbench resolves
// the bus wires from the output enables
//
// What this block does
// - act on edges only with qualifier low
// - qualifier high stretches cycle, never deselects
// - capture every synchronous input on the edge
// - read data leaves through output registers
// - capture incoming bus data on the edge
// - drive data of previously registered read address
// - output drive enable high tristates the bus
// - tristate in write data, after/while deselected
// - parity lines act as data, per lane
// - strap high interleaved, low linear burst
// - unconnected strap means interleaved order
// - sleep input parks device, keeps stored data
// - sleep input pulled down, defaults awake
// - selected load with qualifier low latches address
// - write strobe with address picks read/write
// - byte selects allow partial writes
// - deselect uses the same pipeline latency
// - selected only with one low, two high, three low
// - advance high steps the burst counter
// - each byte select owns one lane
// - read data drives after the following edge
`timescale 1ns/1ps
`include "pss_cfg.svh"

module pss_sram_port (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clockQualifier_n,
    input wire logic selectOne_n,
    input wire logic selectTwo,
    input wire logic selectThree_n,
    input wire logic advanceOrLoad,
    input wire logic writeStrobe_n,
    input wire logic [`PSS_LANES-1:0] byteWriteSel_n,
    input wire logic [`PSS_ADDR_W-1:0] addrIn,
    input wire logic outputDrive_n,
    input wire logic burstOrderStrap,
    input wire logic sleepRequest,
    input wire logic [`PSS_DATA_W-1:0] dataIn,
    output logic [`PSS_DATA_W-1:0] dataOut,
    output logic dataOe_n,
    input wire logic [`PSS_LANES-1:0] parityLinesIn,
    output logic [`PSS_LANES-1:0] parityLinesOut,
    output logic parityLinesOe_n
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic active;
    logic selected;
    logic asleep;
    logic driveAllowed;
    logic fifoInReady;
    logic fifoInValid;
    logic fifoOutValid;
    logic fifoPop;
    logic [$bits(pss_pkg::pss_wr_t)-1:0] fifoOutRaw;
    pss_pkg::pss_wr_t fifoOutData;
    pss_pkg::pss_wr_t wrCapture;
    pss_pkg::pss_cmd_t addrStage_ff;
    pss_pkg::pss_cmd_t dataStage_ff;
    pss_pkg::pss_cmd_t nxt_addrStage;
    pss_pkg::pss_order_t burstOrder_ff;
    pss_pkg::pss_word_t readWord_ff;
    logic [`PSS_BURST_W-1:0] burstBase_ff;
    logic [`PSS_BURST_W-1:0] burstCnt_ff;
    logic [`PSS_BURST_W-1:0] nxt_burstCnt;
    logic strapTaken_ff;
    logic [`PSS_SLEEP_CYCLES-1:0] sleepPipe_ff;
    pss_pkg::pss_word_t memArray [0:(1<<`PSS_ADDR_W)-1];

    // ------------------------------------------------------------
    // edge qualification and select decode
    // ------------------------------------------------------------
    // a full write fifo freezes the port exactly like a held qualifier,
    // so no captured write is ever dropped
    assign active = !clockQualifier_n && fifoInReady;
    assign selected = !selectOne_n && selectTwo && !selectThree_n && !asleep;

    // ------------------------------------------------------------
    // sleep and strap
    // ------------------------------------------------------------
    // entry and exit each take two edges; the pipe resets to awake so a
    // pin held low by its pad pull-down never parks the device
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleepPipe_ff <= '0;
        end else begin
            sleepPipe_ff <= {sleepPipe_ff[`PSS_SLEEP_CYCLES-2:0], sleepRequest};
        end
    end

    assign asleep = sleepPipe_ff[`PSS_SLEEP_CYCLES-1];

    // strap sampled once after reset; later changes are not followed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            burstOrder_ff <= pss_pkg::PSS_INTERLEAVED;
            strapTaken_ff <= 1'b0;
        end else if (!strapTaken_ff) begin
            burstOrder_ff <= pss_pkg::pss_order_t'(burstOrderStrap);
            strapTaken_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // address stage: load or burst advance
    // ------------------------------------------------------------
    always_comb begin
        nxt_addrStage = addrStage_ff;
        nxt_burstCnt = burstCnt_ff;
        if (!advanceOrLoad) begin
            nxt_burstCnt = '0;
            nxt_addrStage.valid = selected;
            nxt_addrStage.write = !writeStrobe_n;
            nxt_addrStage.addr = addrIn;
        end else if (asleep) begin
            nxt_addrStage.valid = 1'b0;
        end else begin
            // selects and write strobe are ignored while advancing
            nxt_burstCnt = burstCnt_ff + 1'b1;
            if (burstOrder_ff == pss_pkg::PSS_INTERLEAVED) begin
                nxt_addrStage.addr[`PSS_BURST_W-1:0] = burstBase_ff ^ nxt_burstCnt;
            end else begin
                nxt_addrStage.addr[`PSS_BURST_W-1:0] = burstBase_ff + nxt_burstCnt;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            addrStage_ff <= '0;
            burstCnt_ff <= '0;
            burstBase_ff <= '0;
        end else if (active) begin
            addrStage_ff <= nxt_addrStage;
            burstCnt_ff <= nxt_burstCnt;
            if (!advanceOrLoad) begin
                burstBase_ff <= addrIn[`PSS_BURST_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // data stage and read output register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dataStage_ff <= '0;
        end else if (active) begin
            dataStage_ff <= addrStage_ff;
        end
    end

    // no forwarding: a read within two edges of a write to the same word
    // returns the word as it stood before that write
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            readWord_ff <= '0;
        end else if (active && addrStage_ff.valid && !addrStage_ff.write) begin
            readWord_ff <= memArray[addrStage_ff.addr];
        end
    end

    // ------------------------------------------------------------
    // bus drive
    // ------------------------------------------------------------
    // the data stage holds the deselect of the previous cycle during the
    // first cycle after a fresh select, so that cycle stays tristate too
    assign driveAllowed = dataStage_ff.valid && !dataStage_ff.write && !asleep;
    assign dataOe_n = !(driveAllowed && !outputDrive_n);
    assign parityLinesOe_n = dataOe_n;
    assign dataOut = readWord_ff.data;
    assign parityLinesOut = readWord_ff.parity;

    // ------------------------------------------------------------
    // write capture and commit
    // ------------------------------------------------------------
    assign fifoInValid = active && dataStage_ff.valid && dataStage_ff.write;
    assign wrCapture = {dataStage_ff.addr, byteWriteSel_n, parityLinesIn, dataIn};
    assign fifoOutData = pss_pkg::pss_wr_t'(fifoOutRaw);
    // commits pause in sleep so the array is left untouched
    assign fifoPop = fifoOutValid && !asleep;

    pss_fifo #(
        .WIDTH($bits(pss_pkg::pss_wr_t)),
        .DEPTH(`PSS_FIFO_DEPTH)
    ) u_wrFifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(wrCapture),
        .outValid(fifoOutValid),
        .outReady(!asleep),
        .outData(fifoOutRaw)
    );

    always_ff @(posedge sys_clk) begin
        if (fifoPop) begin
            for (int k = 0; k < `PSS_LANES; k++) begin
                if (!fifoOutData.laneSel_n[k]) begin
                    memArray[fifoOutData.addr].data[k*`PSS_LANE_W +: `PSS_LANE_W] <=
                        fifoOutData.word.data[k*`PSS_LANE_W +: `PSS_LANE_W];
                    memArray[fifoOutData.addr].parity[k] <= fifoOutData.word.parity[k];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    property p_qualHold;
        clockQualifier_n |=> $stable(addrStage_ff) && $stable(dataStage_ff);
    endproperty
    a_qualHold: assert property (p_qualHold) else $error("state moved with qualifier high");

    property p_noDeselect;
        clockQualifier_n && addrStage_ff.valid |=> addrStage_ff.valid;
    endproperty
    a_noDeselect: assert property (p_noDeselect) else $error("qualifier deselected");

    property p_load;
        active && !advanceOrLoad && selected
            |=> addrStage_ff.valid && addrStage_ff.addr == $past(addrIn);
    endproperty
    a_load: assert property (p_load) else $error("selected load lost address");

    property p_type;
        active && !advanceOrLoad && selected |=> addrStage_ff.write == !$past(writeStrobe_n);
    endproperty
    a_type: assert property (p_type) else $error("access type wrong");

    property p_deselect;
        active && !advanceOrLoad && (selectOne_n || !selectTwo || selectThree_n)
            |=> !addrStage_ff.valid;
    endproperty
    a_deselect: assert property (p_deselect) else $error("select decode wrong");

    // counter, base and low address bits are separate flops, so the step is
    // judged by how they relate afterwards, not by replaying the next-state logic
    property p_burstInter;
        active && advanceOrLoad && !asleep && burstOrder_ff == pss_pkg::PSS_INTERLEAVED
            |=> (addrStage_ff.addr[1:0] ^ burstBase_ff) == burstCnt_ff;
    endproperty
    a_burstInter: assert property (p_burstInter) else $error("interleaved step wrong");

    property p_burstLin;
        active && advanceOrLoad && !asleep && burstOrder_ff == pss_pkg::PSS_LINEAR
            |=> 2'(addrStage_ff.addr[1:0] - burstBase_ff) == burstCnt_ff;
    endproperty
    a_burstLin: assert property (p_burstLin) else $error("linear step wrong");

    property p_burstStep;
        active && advanceOrLoad && !asleep |=> burstCnt_ff == 2'($past(burstCnt_ff) + 2'h1);
    endproperty
    a_burstStep: assert property (p_burstStep) else $error("burst counter did not step");

    property p_burstHigh;
        active && advanceOrLoad
            |=> addrStage_ff.addr[`PSS_ADDR_W-1:`PSS_BURST_W]
                == $past(addrStage_ff.addr[`PSS_ADDR_W-1:`PSS_BURST_W]);
    endproperty
    a_burstHigh: assert property (p_burstHigh) else $error("burst touched upper address");

    // the output enable is asynchronous, so it is judged in the drive cycle itself
    property p_readLatency;
        active && addrStage_ff.valid && !addrStage_ff.write
            |=> (!asleep && !outputDrive_n) |-> !dataOe_n;
    endproperty
    a_readLatency: assert property (p_readLatency) else $error("read data not driven");

    property p_oeMask;
        outputDrive_n |-> dataOe_n && parityLinesOe_n;
    endproperty
    a_oeMask: assert property (p_oeMask) else $error("drove with enable high");

    property p_writeTri;
        !dataStage_ff.valid || dataStage_ff.write |-> dataOe_n;
    endproperty
    a_writeTri: assert property (p_writeTri) else $error("drove in write or deselect");

    property p_deselPipe;
        active && !advanceOrLoad && !selected ##1 active |=> dataOe_n;
    endproperty
    a_deselPipe: assert property (p_deselPipe) else $error("deselect latency wrong");

    property p_capture;
        active && addrStage_ff.valid && addrStage_ff.write ##1 active |-> fifoInValid;
    endproperty
    a_capture: assert property (p_capture) else $error("write data not captured");

    property p_sleep;
        asleep |-> dataOe_n && !fifoPop;
    endproperty
    a_sleep: assert property (p_sleep) else $error("activity during sleep");

    property p_sleepLoad;
        asleep && active && !advanceOrLoad |=> !addrStage_ff.valid;
    endproperty
    a_sleepLoad: assert property (p_sleepLoad) else $error("access started while asleep");

    // read data moves only on a qualified edge, never combinationally
    property p_readHold;
        !active |=> $stable(readWord_ff);
    endproperty
    a_readHold: assert property (p_readHold) else $error("output register moved while frozen");

    property p_strapHold;
        strapTaken_ff |=> $stable(burstOrder_ff);
    endproperty
    a_strapHold: assert property (p_strapHold) else $error("burst order changed in operation");

    // the fifo can only back up during sleep, and then by three words at most
    property p_fifoRoom;
        fifoInReady;
    endproperty
    a_fifoRoom: assert property (p_fifoRoom) else $error("write fifo filled up");

    // ------------------------------------------------------------
    // scenario covers
    // ------------------------------------------------------------
    c_read: cover property (active && addrStage_ff.valid && !addrStage_ff.write ##1 !dataOe_n);
    c_write: cover property (fifoInValid ##1 fifoPop);
    c_burst: cover property (active && advanceOrLoad && addrStage_ff.valid [*3]);
    c_sleep: cover property (!asleep ##1 asleep);
    c_stall: cover property (clockQualifier_n ##1 !clockQualifier_n);

endmodule

// file: tb/pss_ctrl_model.sv
// controller model: drives the sram port's control pins and its half of the bus
// assumes the bench resolves the shared bus from the device's enables alone and only checks busDrive
`timescale 1ns/1ps
`include "pss_cfg.svh"

module pss_ctrl_model (
    input wire logic sys_clk,
    output logic clockQualifier_n,
    output logic selectOne_n,
    output logic selectTwo,
    output logic selectThree_n,
    output logic advanceOrLoad,
    output logic writeStrobe_n,
    output logic [3:0] byteWriteSel_n,
    output logic [`PSS_ADDR_W-1:0] addrIn,
    output pss_pkg::pss_word_t busOut,
    output logic busDrive
);
    logic pendWr;
    logic burstWr;
    logic [3:0] pendBe;
    pss_pkg::pss_word_t pendData;
    logic nextWr;
    logic [3:0] nextBe;
    pss_pkg::pss_word_t nextData;

    initial begin
        {clockQualifier_n, selectTwo, selectThree_n, advanceOrLoad} = 4'h4;
        {selectOne_n, writeStrobe_n, busDrive, pendWr, burstWr} = 5'h18;
        byteWriteSel_n = 4'hF;
        pendBe = 4'hF;
        addrIn = '0;
        busOut = '0;
        pendData = '0;
        nextWr = 1'b0;
        nextBe = 4'hF;
        nextData = '0;
    end

    // ----------------------------------------------------------------
    // one command per call: 0 deselect, 1 read, 2 write, 3 advance
    // ----------------------------------------------------------------
    task automatic step(input logic [1:0] kind, input logic [`PSS_ADDR_W-1:0] a,
                        input pss_pkg::pss_word_t d, input logic [3:0] be,
                        input logic [2:0] s = 3'h2);
        @(posedge sys_clk);
        clockQualifier_n <= 1'b0;
        selectOne_n <= s[2] | (kind == 2'h0);
        selectTwo <= s[1];
        selectThree_n <= s[0];
        advanceOrLoad <= (kind == 2'h3);
        writeStrobe_n <= (kind != 2'h2);
        addrIn <= a;
        // write data trails its address by two qualified edges: the beat
        // registered two calls ago goes out now, for capture at the next edge
        byteWriteSel_n <= pendBe;
        busDrive <= pendWr;
        // released bus shows no stale value
        busOut <= pendWr ? pendData : ~busOut;
        pendWr = nextWr;
        pendData = nextData;
        pendBe = nextBe;
        if (kind != 2'h3) burstWr = (kind == 2'h2);
        nextWr = burstWr;
        nextData = d;
        nextBe = nextWr ? be : 4'hF;
    endtask

    // garbage on the inputs while stretched must be ignored
    task automatic stall(input int n);
        @(posedge sys_clk);
        clockQualifier_n <= 1'b1;
        addrIn <= ~addrIn;
        writeStrobe_n <= ~writeStrobe_n;
        repeat (n - 1) @(posedge sys_clk);
    endtask
endmodule

// file: tb/pipelined_sync_sram_port_tb.sv
// self-checking bench for the sram port: reference pipeline plus scenarios
// assumes pss_ctrl_model drives the control pins and write data
`timescale 1ns/1ps
`include "pss_cfg.svh"

module pipelined_sync_sram_port_tb;
    localparam logic [1:0] DES = 2'h0;
    localparam logic [1:0] RD = 2'h1;
    localparam logic [1:0] WR = 2'h2;
    localparam logic [1:0] ADV = 2'h3;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic outputDrive_n = 1'b0;
    logic burstOrderStrap = 1'b1;
    logic sleepRequest = 1'b0;
    logic clockQualifier_n, selectOne_n, selectTwo, selectThree_n, advanceOrLoad;
    logic writeStrobe_n, dataOe_n, parityLinesOe_n, busDrive, expOe;
    logic [3:0] byteWriteSel_n, parityLinesOut;
    logic [`PSS_ADDR_W-1:0] addrIn;
    logic [31:0] dataOut;
    logic [1:0] cnt, lo;
    pss_pkg::pss_word_t busOut, busData, old;
    pss_pkg::pss_cmd_t cur, r1, r2, ld;
    pss_pkg::pss_word_t shadow [int];
    int n_fail = 0;
    int total_checks = 0;

    always #5 sys_clk = ~sys_clk;
    assign busData.data = dataOe_n ? busOut.data : dataOut;
    assign busData.parity = parityLinesOe_n ? busOut.parity : parityLinesOut;

    pss_sram_port u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .clockQualifier_n(clockQualifier_n), .selectOne_n(selectOne_n),
        .selectTwo(selectTwo), .selectThree_n(selectThree_n),
        .advanceOrLoad(advanceOrLoad), .writeStrobe_n(writeStrobe_n),
        .byteWriteSel_n(byteWriteSel_n), .addrIn(addrIn), .outputDrive_n(outputDrive_n),
        .burstOrderStrap(burstOrderStrap), .sleepRequest(sleepRequest),
        .dataIn(busData.data), .dataOut(dataOut), .dataOe_n(dataOe_n),
        .parityLinesIn(busData.parity), .parityLinesOut(parityLinesOut),
        .parityLinesOe_n(parityLinesOe_n));

    pss_ctrl_model u_ctrl (.sys_clk(sys_clk), .clockQualifier_n(clockQualifier_n),
        .selectOne_n(selectOne_n), .selectTwo(selectTwo), .selectThree_n(selectThree_n),
        .advanceOrLoad(advanceOrLoad), .writeStrobe_n(writeStrobe_n),
        .byteWriteSel_n(byteWriteSel_n), .addrIn(addrIn), .busOut(busOut),
        .busDrive(busDrive));

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic pss_pkg::pss_word_t merge(pss_pkg::pss_word_t o, n, logic [3:0] be_n);
        for (int k = 0; k < 4; k++) begin
            if (!be_n[k]) begin
                o.data[8*k +: 8] = n.data[8*k +: 8];
                o.parity[k] = n.parity[k];
            end
        end
        return o;
    endfunction

    function automatic pss_pkg::pss_word_t dv(logic [`PSS_ADDR_W-1:0] a);
        return {a[3:0], ~a[12:0], a};
    endfunction

    // ----------------------------------------------------------------
    // reference pipeline: r1 = registered command, r2 = data stage
    // ----------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {cur, r1, r2, cnt} <= '0;
        end else if (!clockQualifier_n) begin
            r2 <= r1;
            if (r2.valid && r2.write) begin
                old = shadow.exists(r2.addr) ? shadow[r2.addr] : 'x;
                shadow[r2.addr] = merge(old, busData, byteWriteSel_n);
            end
            if (!advanceOrLoad) begin
                ld = '{!selectOne_n && selectTwo && !selectThree_n, !writeStrobe_n, addrIn};
                cur <= ld;
                r1 <= ld;
                cnt <= 2'h0;
            end else begin
                lo = burstOrderStrap ? cur.addr[1:0] ^ (cnt + 2'h1) : cur.addr[1:0] + cnt + 2'h1;
                r1 <= '{cur.valid, cur.write, {cur.addr[`PSS_ADDR_W-1:2], lo}};
                cnt <= cnt + 2'h1;
            end
        end
    end

    always @(negedge sys_clk) begin
        if (rst_n) begin
            expOe = !(r2.valid && !r2.write && !outputDrive_n);
            chk(dataOe_n, expOe);
            chk(parityLinesOe_n, expOe);
            if (!expOe && shadow.exists(r2.addr))
                chk({parityLinesOut, dataOut}, shadow[r2.addr]);
            if (busDrive) chk(dataOe_n, 1'b1);
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic idle(input int n);
        repeat (n) u_ctrl.step(DES, '0, '0, 4'hF);
    endtask
    task automatic wr(input logic [`PSS_ADDR_W-1:0] a);
        u_ctrl.step(WR, a, dv(a), 4'h0);
    endtask
    task automatic rd(input logic [`PSS_ADDR_W-1:0] a);
        u_ctrl.step(RD, a, '0, 4'hF);
    endtask

    task automatic t_reset(input logic strap);
        rst_n <= 1'b0;
        burstOrderStrap <= strap;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk(dataOe_n, 1'b1);
        idle(2);
    endtask

    task automatic t_b2b();
        for (int i = 0; i < 4; i++) wr(19'h10 + 19'(i));
        idle(4);
        rd(19'h10); wr(19'h14); rd(19'h11); wr(19'h15); rd(19'h12); rd(19'h13);
        idle(4);
        rd(19'h14); rd(19'h15); idle(2);
    endtask

    task automatic t_lanes();
        for (int k = 0; k < 4; k++) begin
            wr(19'h20);
            u_ctrl.step(WR, 19'h20, '0, ~(4'h1 << k));
            idle(4);
            rd(19'h20); idle(1);
        end
    endtask

    task automatic t_sel_oe();
        wr(19'h30); idle(4);
        for (int s = 0; s < 8; s++) u_ctrl.step(RD, 19'h30, '0, 4'hF, 3'(s));
        idle(2);
        rd(19'h10); outputDrive_n <= 1'b1;
        rd(19'h11); idle(1); outputDrive_n <= 1'b0; idle(1);
    endtask

    task automatic t_stall();
        rd(19'h10); u_ctrl.stall(3); rd(19'h11); u_ctrl.stall(2);
        wr(19'h40); u_ctrl.stall(2); idle(1); u_ctrl.stall(2); idle(5);
        rd(19'h40); idle(2);
    endtask

    task automatic t_sleep();
        wr(19'h60); idle(4);
        sleepRequest <= 1'b1;
        idle(6);
        sleepRequest <= 1'b0;
        idle(4);
        rd(19'h60); idle(2);
    endtask

    task automatic t_burst(input logic strap);
        t_reset(strap);
        u_ctrl.step(WR, 19'h51, 36'h1, 4'h0);
        for (int i = 2; i < 5; i++) u_ctrl.step(ADV, '0, 36'(i), 4'h0);
        idle(4);
        for (int i = 0; i < 4; i++) rd(19'h50 + 19'(i));
        idle(2);
        rd(19'h51);
        repeat (3) u_ctrl.step(ADV, '0, '0, 4'hF);
        idle(2);
    endtask

    initial begin
        #200000;
        n_fail++;
        conclude();
    end

    initial begin
        t_reset(1'b1);
        t_b2b();
        t_lanes();
        t_sel_oe();
        t_stall();
        t_sleep();
        t_burst(1'b0);
        t_burst(1'b1);
        conclude();
    end
endmodule
